// [logic/isd_pkg.sv]
// Purpose: constants for the store/sub/test instruction slice
// Assumes: 16-bit instructions, 32-bit data, 16 general registers
// Notes: opcode patterns hold the fixed high bits of each encoding
package isd_pkg;
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam logic [15:0] OP_SYNC = 16'h0001;
  localparam logic [15:0] OP_STOP = 16'h0004;
  localparam logic [15:0] OP_WAIT = 16'h0005;
  localparam logic [13:0] OP_TRAP = 14'h0002;
  localparam logic [11:0] OP_STM = 12'h007;
  localparam logic [11:0] OP_STQ = 12'h005;
  localparam logic [11:0] OP_TSTNBZ = 12'h019;
  localparam logic [11:0] OP_XSR = 12'h380;
  localparam logic [7:0] OP_SUBC = 8'h07;
  localparam logic [7:0] OP_SUBU = 8'h05;
  localparam logic [7:0] OP_TST = 8'h0E;
  localparam logic [7:0] OP_XOR = 8'h17;
  localparam logic [6:0] OP_SUBI = 7'h12;
  localparam logic [3:0] REG_LAST = 4'hF;
  localparam logic [3:0] REG_QUAD_FIRST = 4'h4;
  localparam logic [3:0] REG_QUAD_LAST = 4'h7;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [31:0] RESET_PC = 32'h0000_0000;
  localparam logic [31:0] TRAP_VEC_BASE = 32'h0000_0040;
  localparam int unsigned TRAP_NUM_POS = 0;
  localparam int unsigned FIRST_FIELD_POS = 0;
  localparam int unsigned SECOND_FIELD_POS = 4;
  localparam int unsigned OIMM_POS = 4;
  typedef enum logic [5:0] {
    ISD_FETCH = 6'b000001,
    ISD_EXEC = 6'b000010,
    ISD_STORE = 6'b000100,
    ISD_SYNC = 6'b001000,
    ISD_SLEEP = 6'b010000,
    ISD_TRAP = 6'b100000
  } isd_state_e;
endpackage

// [logic/isd_alu.sv]
// Purpose: arithmetic and flag unit for the slice
// Assumes: operation codes from the decoder in the core
// Notes: purely combinational
`timescale 1ns/1ps
module isd_alu (
  input wire logic [2:0] op,
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  input wire logic [4:0] offset_five_bit_immediate,
  input wire logic c_in,
  output logic [31:0] result,
  output logic c_out,
  output logic wr_reg,
  output logic wr_c
);
  // op: 0 subc, 1 subi, 2 subu, 3 tst, 4 tstnbz, 5 xor, 6 xsr
  logic [32:0] subc_w;
  logic [31:0] oimm_w;
  assign subc_w = {1'b0, a} + {1'b0, ~b} + {32'h0000_0000, c_in};
  assign oimm_w = {27'h0, offset_five_bit_immediate} + 32'h0000_0001;
  always_comb
  begin
    result = a;
    c_out = c_in;
    wr_reg = 1'b0;
    wr_c = 1'b0;
    case (op)
      3'h0:
      begin
        result = subc_w[31:0];
        c_out = subc_w[32];
        wr_reg = 1'b1;
        wr_c = 1'b1;
      end
      3'h1:
      begin
        result = a - oimm_w;
        wr_reg = 1'b1;
      end
      3'h2:
      begin
        result = a - b;
        wr_reg = 1'b1;
      end
      3'h3:
      begin
        c_out = |(a & b);
        wr_c = 1'b1;
      end
      3'h4:
      begin
        c_out = (|a[7:0]) & (|a[15:8]) & (|a[23:16]) & (|a[31:24]);
        wr_c = 1'b1;
      end
      3'h5:
      begin
        result = a ^ b;
        wr_reg = 1'b1;
      end
      3'h6:
      begin
        result = {c_in, a[31:1]};
        c_out = a[0];
        wr_reg = 1'b1;
        wr_c = 1'b1;
      end
      default:
      begin
        result = a;
      end
    endcase
  end
endmodule

// [logic/isd_core.sv]
// Purpose: decode and execute of stores, sleep, sync, trap, sub, test
// Assumes: one instruction offered at a time with its pc
// Notes: register file held here; memory takes one word per ack
// Operation
// - store-multiple writes first field..R15 ascending from R0, R0 unchanged
// - quadrant store writes R4..R7 ascending from base, base unchanged
// - base inside R4..R7 stores any value; software avoids it
// - stop halts core clock in stop state until an interrupt
// - wait halts execution until a peripheral interrupt
// - subtract with carry: a minus b minus not carry, carry out
// - offset immediate subtract takes field plus one, carry kept
// - plain subtract writes a minus b, carry kept
// - sync stalls issue until outstanding work completes
// - trap always raises exception; 2-bit field picks vector
// - test sets carry when and of registers is non-zero
// - no-zero-byte test sets carry when no byte is zero
// - exclusive or writes first register, carry kept
// - extended shift right rotates through carry
// - traps and privilege faults caught at decode, pc of itself
`timescale 1ns/1ps
module isd_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] instr,
  input wire logic [31:0] instr_pc,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic supervisor,
  input wire logic irq,
  input wire logic mem_busy,
  output logic mem_req,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  output logic clk_halt,
  output logic stop_mode,
  output logic wait_mode,
  output logic exc_valid,
  output logic [31:0] exc_vector,
  output logic [31:0] exc_pc,
  output logic priv_fault,
  output logic carry
);
  default clocking core_cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========================================================
  // decode
  isd_pkg::isd_state_e state_q, state_d;
  logic [31:0] regs_q [16];
  logic [3:0] rx;
  logic [3:0] second_operand_register;
  logic [4:0] offset_five_bit_immediate;
  logic [1:0] trap_number_field;
  logic dec_stm, dec_stq, dec_stop, dec_wait, dec_sync, dec_trap;
  logic dec_alu, is_priv, take;
  logic [2:0] alu_op;
  assign rx = instr[3:0];
  assign second_operand_register = instr[7:4];
  assign offset_five_bit_immediate = instr[8:4];
  assign trap_number_field = instr[1:0];
  assign dec_sync = instr == isd_pkg::OP_SYNC;
  assign dec_stop = instr == isd_pkg::OP_STOP;
  assign dec_wait = instr == isd_pkg::OP_WAIT;
  assign dec_trap = instr[15:2] == isd_pkg::OP_TRAP;
  assign dec_stm = instr[15:4] == isd_pkg::OP_STM;
  assign dec_stq = instr[15:4] == isd_pkg::OP_STQ;
  assign is_priv = dec_stop | dec_wait;
  always_comb
  begin
    dec_alu = 1'b1;
    alu_op = 3'h0;
    if (instr[15:8] == isd_pkg::OP_SUBC)
      alu_op = 3'h0;
    else if (instr[15:9] == isd_pkg::OP_SUBI)
      alu_op = 3'h1;
    else if (instr[15:8] == isd_pkg::OP_SUBU)
      alu_op = 3'h2;
    else if (instr[15:8] == isd_pkg::OP_TST)
      alu_op = 3'h3;
    else if (instr[15:4] == isd_pkg::OP_TSTNBZ)
      alu_op = 3'h4;
    else if (instr[15:8] == isd_pkg::OP_XOR)
      alu_op = 3'h5;
    else if (instr[15:4] == isd_pkg::OP_XSR)
      alu_op = 3'h6;
    else
      dec_alu = 1'b0;
  end
  // ==========================================================
  // execute unit
  logic [31:0] alu_res;
  logic alu_c, alu_wr, alu_wc;
  isd_alu u_alu (
    .op(alu_op),
    .a(regs_q[rx]),
    .b(regs_q[second_operand_register]),
    .offset_five_bit_immediate(offset_five_bit_immediate),
    .c_in(carry),
    .result(alu_res),
    .c_out(alu_c),
    .wr_reg(alu_wr),
    .wr_c(alu_wc)
  );
  // ==========================================================
  // sequencing
  logic [3:0] cur_q, last_q, cur_nx;
  assign cur_nx = cur_q + 4'h1;
  logic store_done;
  assign take = (state_q == isd_pkg::ISD_FETCH) && instr_valid;
  assign store_done = mem_ack && (cur_q == last_q);
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      isd_pkg::ISD_FETCH:
        if (instr_valid)
        begin
          if (is_priv && !supervisor)
            state_d = isd_pkg::ISD_TRAP;
          else if (dec_trap)
            state_d = isd_pkg::ISD_TRAP;
          else if (dec_stm || dec_stq)
            state_d = isd_pkg::ISD_STORE;
          else if (dec_sync)
            state_d = isd_pkg::ISD_SYNC;
          else if (is_priv)
            state_d = isd_pkg::ISD_SLEEP;
        end
      isd_pkg::ISD_STORE:
        if (store_done)
          state_d = isd_pkg::ISD_FETCH;
      isd_pkg::ISD_SYNC:
        if (!mem_busy && !mem_req)
          state_d = isd_pkg::ISD_FETCH;
      isd_pkg::ISD_SLEEP:
        if (irq)
          state_d = isd_pkg::ISD_FETCH;
      isd_pkg::ISD_TRAP:
        state_d = isd_pkg::ISD_FETCH;
      default:
        state_d = isd_pkg::ISD_FETCH;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      state_q <= isd_pkg::ISD_FETCH;
    else
      state_q <= state_d;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stop_mode <= 1'b0;
      wait_mode <= 1'b0;
      clk_halt <= 1'b0;
    end
    else if (take && supervisor && (dec_stop || dec_wait))
    begin
      stop_mode <= dec_stop;
      wait_mode <= dec_wait;
      clk_halt <= 1'b1;
    end
    else if (state_q == isd_pkg::ISD_SLEEP && irq)
    begin
      stop_mode <= 1'b0;
      wait_mode <= 1'b0;
      clk_halt <= 1'b0;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      exc_valid <= 1'b0;
      exc_vector <= isd_pkg::RESET_PC;
      exc_pc <= isd_pkg::RESET_PC;
      priv_fault <= 1'b0;
    end
    else
    begin
      exc_valid <= 1'b0;
      priv_fault <= 1'b0;
      if (take && ((is_priv && !supervisor) || dec_trap))
      begin
        exc_valid <= 1'b1;
        exc_pc <= instr_pc;
        priv_fault <= is_priv && !supervisor;
        exc_vector <= isd_pkg::TRAP_VEC_BASE
          + {28'h0, trap_number_field, 2'b00};
      end
    end
  end
  // ==========================================================
  // stores and register file
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mem_req <= 1'b0;
      mem_addr <= isd_pkg::RESET_PC;
      mem_wdata <= 32'h0000_0000;
      cur_q <= 4'h0;
      last_q <= 4'h0;
    end
    else if (take && dec_stm)
    begin
      cur_q <= rx;
      last_q <= isd_pkg::REG_LAST;
      mem_req <= 1'b1;
      mem_addr <= regs_q[0];
      mem_wdata <= regs_q[rx];
    end
    else if (take && dec_stq)
    begin
      cur_q <= isd_pkg::REG_QUAD_FIRST;
      last_q <= isd_pkg::REG_QUAD_LAST;
      mem_req <= 1'b1;
      mem_addr <= regs_q[rx];
      mem_wdata <= regs_q[isd_pkg::REG_QUAD_FIRST];
    end
    else if (state_q == isd_pkg::ISD_STORE && mem_ack)
    begin
      cur_q <= cur_nx;
      mem_addr <= mem_addr + isd_pkg::WORD_STEP;
      mem_wdata <= regs_q[cur_nx];
      mem_req <= !store_done;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      carry <= 1'b0;
    else if (take && dec_alu && alu_wc)
      carry <= alu_c;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 16; i++)
        regs_q[i] <= 32'h0000_0000;
    end
    else if (take && dec_alu && alu_wr)
      regs_q[rx] <= alu_res;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      instr_ready <= 1'b0;
    else
      instr_ready <= state_d == isd_pkg::ISD_FETCH && !take;
  end
  // ==========================================================
  // checks
  logic tst_nz;
  assign tst_nz = |(regs_q[rx] & regs_q[second_operand_register]);
  sequence s_word_taken;
    state_q == isd_pkg::ISD_STORE && mem_ack && !store_done;
  endsequence
  chk_store_base_kept: assert property ((take && dec_stm) |=>
    mem_addr == $past(regs_q[0]) && regs_q[0] == $past(regs_q[0]))
    else $error("base pointer changed by store multiple");
  chk_quad_start_reg: assert property ((take && dec_stq) |=>
    cur_q == isd_pkg::REG_QUAD_FIRST && mem_req)
    else $error("quadrant store did not start at R4");
  chk_store_step: assert property (s_word_taken |=>
    mem_req && mem_addr == $past(mem_addr) + isd_pkg::WORD_STEP)
    else $error("store address did not step by one word");
  chk_trap_pc: assert property ((take && dec_trap) |=>
    exc_valid && exc_pc == $past(instr_pc))
    else $error("trap pc wrong");
  chk_trap_vec: assert property ((take && dec_trap) |=>
    exc_vector[3:2] == $past(trap_number_field))
    else $error("trap vector wrong");
  chk_sleep_exit: assert property (
    (state_q == isd_pkg::ISD_SLEEP && irq) |=> !clk_halt)
    else $error("sleep not left on interrupt");
  chk_wait_enter: assert property (
    (take && supervisor && dec_wait) |=> wait_mode && clk_halt)
    else $error("wait not entered");
  chk_sync_hold: assert property (
    (state_q == isd_pkg::ISD_SYNC && mem_busy) |=> !instr_ready)
    else $error("issue during sync");
  chk_tst_carry: assert property (
    (take && dec_alu && alu_op == 3'h3) |=> carry == $past(tst_nz))
    else $error("test carry wrong");
  chk_subi_carry: assert property (
    (take && dec_alu && alu_op == 3'h1) |=> $stable(carry))
    else $error("subtract immediate changed carry");
endmodule

// [tb/isd_mem.sv]
// Purpose: data memory stand-in on the core store port
// Assumes: one word taken per ack pulse
// Notes: lat sets idle cycles per word, busy lingers after each ack
`timescale 1ns/1ps
module isd_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] lat,
  output logic mem_ack,
  output logic mem_busy
);
  logic [31:0] addr_log [32];
  logic [31:0] data_log [32];
  logic [4:0] n_q;
  logic [3:0] wait_q;
  logic [3:0] busy_q;

  assign mem_busy = (busy_q != 4'h0);

  // ==========================================================
  // one ack per word after lat idle cycles, then posted work
  always_ff @(posedge clk)
  begin
    mem_ack <= 1'b0;
    if (busy_q != 4'h0)
      busy_q <= busy_q - 4'h1;
    if (rst)
    begin
      n_q <= 5'h00;
      wait_q <= 4'h0;
      busy_q <= 4'h0;
    end
    else if (mem_req && !mem_ack)
    begin
      if (wait_q >= lat)
      begin
        mem_ack <= 1'b1;
        addr_log[n_q] <= mem_addr;
        data_log[n_q] <= mem_wdata;
        n_q <= n_q + 5'h01;
        wait_q <= 4'h0;
        busy_q <= 4'h6;
      end
      else
        wait_q <= wait_q + 4'h1;
    end
  end
endmodule

// [tb/tb_top.sv]
// Purpose: self-checking bench for the store/sub/test slice
// Assumes: registers clear at reset, stores seen at memory
// Notes: a shadow register model predicts stores and carry
`timescale 1ns/1ps
module tb_top;
  logic clk, rst, instr_valid, instr_ready, supervisor, irq;
  logic mem_busy, mem_req, mem_ack, clk_halt, stop_mode, wait_mode;
  logic exc_valid, priv_fault, carry, c_m;
  logic [15:0] instr;
  logic [15:0] prog [14];
  logic [31:0] instr_pc, mem_addr, mem_wdata, exc_vector, exc_pc;
  logic [31:0] r_m [16];
  logic [3:0] lat;
  int err_total, cmp_count;

  isd_core dut (.clk(clk), .rst(rst), .instr(instr), .instr_pc(instr_pc),
    .instr_valid(instr_valid), .instr_ready(instr_ready),
    .supervisor(supervisor), .irq(irq), .mem_busy(mem_busy),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .clk_halt(clk_halt), .stop_mode(stop_mode),
    .wait_mode(wait_mode), .exc_valid(exc_valid), .exc_vector(exc_vector),
    .exc_pc(exc_pc), .priv_fault(priv_fault), .carry(carry));
  isd_mem mem (.clk(clk), .rst(rst), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .lat(lat), .mem_ack(mem_ack), .mem_busy(mem_busy));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================
  // helpers
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (instr_ready !== 1'b1)
    begin
      tick();
      n++;
      if (n > 200)
      begin
        err_total++;
        $display("ERROR %0t ready timeout", $time);
        tally_and_finish();
      end
    end
  endtask

  task automatic issue(input logic [15:0] op, input logic [31:0] pc);
    wait_ready();
    instr = op;
    instr_pc = pc;
    instr_valid = 1'b1;
    tick();
    instr_valid = 1'b0;
  endtask

  // ==========================================================
  // scenarios
  task automatic alu(input logic [15:0] op);
    logic [3:0] x, y;
    logic [32:0] t;
    x = op[3:0];
    y = op[7:4];
    issue(op, 32'h0000_0200);
    if (op[15:9] == isd_pkg::OP_SUBI)
      r_m[x] = r_m[x] - {27'h0, op[8:4]} - 32'h1;
    else if (op[15:8] == isd_pkg::OP_SUBC)
    begin
      t = {1'b0, r_m[x]} - {1'b0, r_m[y]} - {32'h0, ~c_m};
      r_m[x] = t[31:0];
      c_m = ~t[32];
    end
    else if (op[15:8] == isd_pkg::OP_SUBU)
      r_m[x] = r_m[x] - r_m[y];
    else if (op[15:8] == isd_pkg::OP_TST)
      c_m = |(r_m[x] & r_m[y]);
    else if (op[15:8] == isd_pkg::OP_XOR)
      r_m[x] = r_m[x] ^ r_m[y];
    else if (op[15:4] == isd_pkg::OP_TSTNBZ)
      c_m = &{|r_m[x][31:24], |r_m[x][23:16], |r_m[x][15:8], |r_m[x][7:0]};
    else
    begin
      t = {r_m[x][0], c_m, r_m[x][31:1]};
      r_m[x] = t[31:0];
      c_m = t[32];
    end
    wait_ready();
    chk32(carry, c_m, "carry");
  endtask

  task automatic store(input logic [15:0] op, input logic [31:0] base,
    input int lo, input int hi);
    logic [4:0] n0;
    n0 = mem.n_q;
    issue(op, 32'h0000_0300);
    wait_ready();
    chk32(mem.n_q - n0, hi - lo + 1, "count");
    for (int i = lo; i <= hi; i++)
    begin
      chk32(mem.addr_log[n0], base + 4 * (i - lo), "addr");
      chk32(mem.data_log[n0], r_m[i], "data");
      n0++;
    end
  endtask

  task automatic sync_chk();
    issue(isd_pkg::OP_SYNC, 32'h0000_0310);
    wait_ready();
    chk32(mem_busy, 1'b0, "sync");
  endtask

  task automatic sleep_chk(input logic [15:0] op);
    supervisor = 1'b1;
    issue(op, 32'h0000_0400);
    repeat (4) tick();
    chk32({clk_halt, stop_mode, wait_mode, instr_ready},
      {1'b1, ~op[0], op[0], 1'b0}, "sleep");
    irq = 1'b1;
    wait_ready();
    irq = 1'b0;
    chk32({clk_halt, stop_mode, wait_mode}, 3'h0, "wake");
  endtask

  task automatic exc_chk(input logic [15:0] op, input logic pf);
    logic [31:0] vec;
    int n;
    vec = isd_pkg::TRAP_VEC_BASE + {28'h0, op[1:0], 2'b00};
    issue(op, 32'h0000_0500 + vec);
    n = 0;
    while (exc_valid !== 1'b1 && n < 8)
    begin
      tick();
      n++;
    end
    if (n >= 8)
    begin
      err_total++;
      $display("ERROR %0t exception timeout", $time);
      tally_and_finish();
    end
    chk32({exc_valid, priv_fault, stop_mode}, {1'b1, pf, 1'b0}, "exc");
    chk32(exc_vector, vec, "vector");
    chk32(exc_pc, 32'h0000_0500 + vec, "pc");
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    instr = 16'h0000;
    instr_pc = 32'h0000_0000;
    instr_valid = 1'b0;
    supervisor = 1'b0;
    irq = 1'b0;
    lat = 4'h0;
    c_m = 1'b0;
    err_total = 0;
    cmp_count = 0;
    foreach (r_m[i]) r_m[i] = 32'h0000_0000;
    prog = '{{isd_pkg::OP_SUBI, 5'h00, 4'h4}, {isd_pkg::OP_TST, 8'h44},
      {isd_pkg::OP_SUBI, 5'h1F, 4'h5}, {isd_pkg::OP_SUBI, 5'h07, 4'h2},
      {isd_pkg::OP_SUBI, 5'h03, 4'h0}, {isd_pkg::OP_XOR, 8'h46},
      {isd_pkg::OP_SUBU, 8'h57}, {isd_pkg::OP_SUBC, 8'h48},
      {isd_pkg::OP_TST, 8'hA8}, {isd_pkg::OP_SUBC, 8'h98},
      {isd_pkg::OP_TSTNBZ, 4'h7}, {isd_pkg::OP_TSTNBZ, 4'h4},
      {isd_pkg::OP_XSR, 4'hF}, {isd_pkg::OP_XSR, 4'h4}};
    tick();
    tick();
    rst = 1'b0;
    chk32({mem_req, exc_valid, carry, stop_mode}, 4'h0, "reset");
    foreach (prog[i]) alu(prog[i]);
    store({isd_pkg::OP_STM, 4'h2}, r_m[0], 2, 15);
    sync_chk();
    lat = 4'h3;
    store({isd_pkg::OP_STQ, 4'h2}, r_m[2], 4, 7);
    store({isd_pkg::OP_STM, 4'hE}, r_m[0], 14, 15);
    sleep_chk(isd_pkg::OP_STOP);
    sleep_chk(isd_pkg::OP_WAIT);
    supervisor = 1'b0;
    exc_chk(isd_pkg::OP_STOP, 1'b1);
    exc_chk(isd_pkg::OP_WAIT, 1'b1);
    for (int k = 0; k < 4; k++)
      exc_chk({isd_pkg::OP_TRAP, 2'(k)}, 1'b0);
    tally_and_finish();
  end
endmodule
